// *** psfs_cfg.svh ***
/*
 Constants of the start-up and fault sequencer: offsets, fields, resets, times.
 Assumes a 25 MHz core clock; included by bare name.
*/
`ifndef PSFS_CFG_SVH
`define PSFS_CFG_SVH

// ----------------------------------------------------------------
// Time base
// ----------------------------------------------------------------
`define PSFS_CLK_KHZ        25000
`define PSFS_FAULT_STD_MS   15
`define PSFS_FAULT_EXT_MS   150
`define PSFS_DELAY_MS       120
`define PSFS_CLEAN_PERIODS  2'd3
`define PSFS_DITHER_PCT     4'sd5

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define PSFS_CTRL_OFS       8'h00
`define PSFS_STATUS_OFS     8'h04
`define PSFS_CTRL_RESET     3'h0
`define PSFS_VAR_MSB        2

// ----------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------
`define PSFS_SYNC_W         9
`define PSFS_IX_VCC_START   0
`define PSFS_IX_VCC_MIN     1
`define PSFS_IX_MON         2
`define PSFS_IX_CS_FAULT    3
`define PSFS_IX_CS_SS       4
`define PSFS_IX_FB_SKIP     5
`define PSFS_IX_FB_MINTON   6
`define PSFS_IX_SS_DONE     7
`define PSFS_IX_OSC         8

`endif

// *** psfs_pkg.sv ***
/*
 Types of the start-up and fault sequencer.
 Assumes nothing of its surroundings.
*/
package psfs_pkg;
	// Product variants, A to E
	typedef enum logic [2:0] {
		PSFS_VAR_A,
		PSFS_VAR_B,
		PSFS_VAR_C,
		PSFS_VAR_D,
		PSFS_VAR_E
	} psfs_variant_type;

	// Start-up sequence states
	typedef enum logic [1:0] {
		PSFS_OFF,
		PSFS_DELAY,
		PSFS_WAIT_MON,
		PSFS_ACTIVE
	} psfs_state_type;
endpackage

// *** psfs_if.sv ***
/*
 Carrier between the sequencer core, its synchroniser and its dither generator.
 Assumes all three sit on the same clock.
*/
`timescale 1ns/1ns
`include "psfs_cfg.svh"

interface psfs_if;
	logic [`PSFS_SYNC_W-1:0] raw;
	logic [`PSFS_SYNC_W-1:0] level;
	logic                    period_tick;
	logic signed [3:0]       trim;

	modport sync_mp   (input raw, output level);
	modport dither_mp (input period_tick, output trim);
	modport core_mp   (output raw, input level, output period_tick, input trim);
endinterface

// *** psfs_sync.sv ***
/*
 Two-flop synchronisers for every comparator level that enters the block.
 Assumes raw levels are asynchronous to clk_in.
*/
`timescale 1ns/1ns
`include "psfs_cfg.svh"

module psfs_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Levels
	psfs_if.sync_mp   lanes
);
	// ----------------------------------------------------------------
	// One synchroniser per lane; the first flop feeds only the second
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `PSFS_SYNC_W; i = i + 1) begin : g_lane
			logic meta;
			logic held;
			always_ff @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					meta <= 1'b0;
					held <= 1'b0;
				end else begin
					meta <= lanes.raw[i];
					held <= meta;
				end
			end
			assign lanes.level[i] = held;
		end
	endgenerate
endmodule

// *** psfs_dither.sv ***
/*
 Frequency dither: a triangle trim of the oscillator in percent, one step per period.
 Assumes period_tick is a one-cycle pulse per switching period.
*/
`timescale 1ns/1ns
`include "psfs_cfg.svh"

module psfs_dither (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Period tick in, trim out
	psfs_if.dither_mp dith
);
	logic signed [3:0] trim;
	logic signed [3:0] next_trim;
	logic              rising;
	logic              next_rising;

	// Walk the trim between the band edges, turning at each edge
	always_comb begin
		next_trim   = trim;
		next_rising = rising;
		if (dith.period_tick) begin
			if (rising) begin
				if (trim == `PSFS_DITHER_PCT) begin
					next_rising = 1'b0;
					next_trim   = trim - 4'sd1;
				end else begin
					next_trim = trim + 4'sd1; // R16
				end
			end else begin
				if (trim == -`PSFS_DITHER_PCT) begin
					next_rising = 1'b1;
					next_trim   = trim + 4'sd1;
				end else begin
					next_trim = trim - 4'sd1; // R16
				end
			end
		end
	end

	// Register the dither state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			trim   <= 4'sd0;
			rising <= 1'b1;
		end else begin
			trim   <= next_trim;
			rising <= next_rising;
		end
	end

	assign dith.trim = trim;
endmodule

// *** psfs_sequencer.sv ***
/*
 Start-up, soft-start, brown-out and overload sequencer of a current-mode PWM
 controller, with an AHB-Lite register slave.
 Assumes comparator levels arrive asynchronously and the oscillator period
 arrives as a square wave from the device's own oscillator.
// Overview of operation
// (R1) CS over fault level starts fault timer
// (R2) Timer end latches fault, gate stays off
// (R3) Timer clears after three clean switching periods
// (R4) Latch clears on brown-out or supply minimum
// (R5) Fault time 15 ms, 150 ms variant E
// (R6) Supply start runs 120 ms start-up delay
// (R7) Start-up delay only in variants A-C
// (R8) Soft-start needs delay done and monitor high
// (R9) Soft-start node grounded until soft-start permitted
// (R10) Monitor restart skips the start-up delay
// (R11) Monitor low stops switching, return re-soft-starts
// (R12) Hysteresis sink on while monitor below threshold
// (R13) Grounded monitor pin shuts down, grounds soft-start
// (R14) Soft-start: CS above SS/4 resets drive
// (R15) Low feedback: minimum on-time, then zero duty
// (R16) Dither switching frequency within five percent
// (R17) No synchronisation input, own oscillator only
// (R18) D and E have no start-up delay
// (R19) Gate enable is conjunction of all conditions
// (R20) Long times count the fixed core clock
*/
`timescale 1ns/1ns
`include "psfs_cfg.svh"

module psfs_sequencer #(
	parameter int unsigned FAULT_STD_CYCLES = `PSFS_FAULT_STD_MS * `PSFS_CLK_KHZ,
	parameter int unsigned FAULT_EXT_CYCLES = `PSFS_FAULT_EXT_MS * `PSFS_CLK_KHZ,
	parameter int unsigned DELAY_CYCLES     = `PSFS_DELAY_MS * `PSFS_CLK_KHZ
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Comparator levels
	input  wire logic        vcc_start_in,
	input  wire logic        vcc_min_in,
	input  wire logic        input_monitor_pin_in,
	input  wire logic        cs_fault_in,
	input  wire logic        cs_ss_limit_in,
	input  wire logic        feedback_input_skip_in,
	input  wire logic        feedback_input_min_ton_in,
	input  wire logic        ss_done_in,
	input  wire logic        osc_period_in,
	// Power stage controls
	output logic             gate_enable_out,
	output logic             ss_ground_out,
	output logic             hysteresis_current_sink_out,
	output logic             drive_latch_reset_out,
	output logic             min_ton_out,
	output logic             fault_latched_out,
	output logic signed [3:0] dither_trim_out
);
	localparam logic [21:0] FAULT_STD = 22'(FAULT_STD_CYCLES);
	localparam logic [21:0] FAULT_EXT = 22'(FAULT_EXT_CYCLES);
	localparam logic [21:0] DELAY_LEN = 22'(DELAY_CYCLES);

	// ----------------------------------------------------------------
	// Synchronisers, period edge and dither
	// ----------------------------------------------------------------
	psfs_if lanes ();

	assign lanes.raw = {osc_period_in, ss_done_in, feedback_input_min_ton_in,
		feedback_input_skip_in, cs_ss_limit_in, cs_fault_in,
		input_monitor_pin_in, vcc_min_in, vcc_start_in};

	psfs_sync u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.lanes     (lanes.sync_mp)
	);

	psfs_dither u_dither (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.dith      (lanes.dither_mp)
	);

	logic vcc_start_s;
	logic vmin_s;
	logic mon_s;
	logic cs_fault_s;
	logic cs_ss_s;
	logic fb_skip_s;
	logic fb_minton_s;
	logic ss_done_s;
	logic osc_s;
	logic osc_q;
	logic period_tick;

	assign vcc_start_s = lanes.level[`PSFS_IX_VCC_START];
	assign vmin_s      = lanes.level[`PSFS_IX_VCC_MIN];
	assign mon_s       = lanes.level[`PSFS_IX_MON];
	assign cs_fault_s  = lanes.level[`PSFS_IX_CS_FAULT];
	assign cs_ss_s     = lanes.level[`PSFS_IX_CS_SS];
	assign fb_skip_s   = lanes.level[`PSFS_IX_FB_SKIP];
	assign fb_minton_s = lanes.level[`PSFS_IX_FB_MINTON];
	assign ss_done_s   = lanes.level[`PSFS_IX_SS_DONE];
	assign osc_s       = lanes.level[`PSFS_IX_OSC];

	// Period edge from the own oscillator only; there is no sync pin
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= osc_s;
		end
	end
	assign period_tick       = osc_s & ~osc_q; // R17
	assign lanes.period_tick = period_tick;
	assign dither_trim_out   = lanes.trim; // R16

	// ----------------------------------------------------------------
	// Control register and variant decode
	// ----------------------------------------------------------------
	psfs_pkg::psfs_variant_type variant;
	psfs_pkg::psfs_variant_type next_variant;
	logic                       has_delay;
	logic [21:0]                fault_limit;

	assign has_delay   = (variant <= psfs_pkg::PSFS_VAR_C); // R7 R18
	assign fault_limit = (variant >= psfs_pkg::PSFS_VAR_E) ? FAULT_EXT : FAULT_STD; // R5 R20

	// ----------------------------------------------------------------
	// Start-up sequence
	// ----------------------------------------------------------------
	psfs_pkg::psfs_state_type state;
	psfs_pkg::psfs_state_type next_state;
	logic [21:0]              delay_cnt;
	logic [21:0]              next_delay_cnt;

	// Supply below minimum drops everything back to the off state
	always_comb begin
		next_state     = state;
		next_delay_cnt = delay_cnt;
		if (!vmin_s) begin
			next_state     = psfs_pkg::PSFS_OFF;
			next_delay_cnt = 22'h0;
		end else begin
			case (state)
				psfs_pkg::PSFS_OFF: begin
					if (vcc_start_s) begin
						next_delay_cnt = 22'h0;
						if (has_delay) begin
							next_state = psfs_pkg::PSFS_DELAY; // R6
						end else begin
							next_state = psfs_pkg::PSFS_WAIT_MON; // R7 R18
						end
					end
				end
				psfs_pkg::PSFS_DELAY: begin
					if (delay_cnt == DELAY_LEN - 22'h1) begin
						next_state = psfs_pkg::PSFS_WAIT_MON; // R6
					end else begin
						next_delay_cnt = delay_cnt + 22'h1; // R20
					end
				end
				psfs_pkg::PSFS_WAIT_MON: begin
					if (mon_s) begin
						next_state = psfs_pkg::PSFS_ACTIVE; // R8 R10
					end
				end
				psfs_pkg::PSFS_ACTIVE: begin
					if (!mon_s) begin
						next_state = psfs_pkg::PSFS_WAIT_MON; // R11 R13
					end
				end
				default: begin
					next_state = psfs_pkg::PSFS_OFF;
				end
			endcase
		end
	end

	// Register the sequence state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state     <= psfs_pkg::PSFS_OFF;
			delay_cnt <= 22'h0;
		end else begin
			state     <= next_state;
			delay_cnt <= next_delay_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Overload fault timer and latch
	// ----------------------------------------------------------------
	logic        fault_pending;
	logic        next_fault_pending;
	logic        fault_latched;
	logic        next_fault_latched;
	logic [21:0] fault_cnt;
	logic [21:0] next_fault_cnt;
	logic [1:0]  clean_cnt;
	logic [1:0]  next_clean_cnt;
	logic        clear_latch;
	logic        expire;

	assign clear_latch = ~mon_s | ~vmin_s; // R4
	assign expire      = (fault_pending | cs_fault_s) && (fault_cnt >= fault_limit - 22'h1);

	// Expiry wins over the clean-period clear so a fault near the end still latches
	always_comb begin
		next_fault_pending = fault_pending;
		next_fault_latched = fault_latched;
		next_fault_cnt     = fault_cnt;
		next_clean_cnt     = clean_cnt;
		if (clear_latch) begin
			next_fault_pending = 1'b0; // R4
			next_fault_latched = 1'b0;
			next_fault_cnt     = 22'h0;
			next_clean_cnt     = 2'h0;
		end else if (!fault_latched && (fault_pending || cs_fault_s)) begin
			if (expire) begin
				next_fault_latched = 1'b1; // R2
				next_fault_pending = 1'b0;
				next_fault_cnt     = 22'h0;
				next_clean_cnt     = 2'h0;
			end else begin
				next_fault_pending = 1'b1; // R1
				next_fault_cnt     = fault_cnt + 22'h1;
				if (cs_fault_s) begin
					next_clean_cnt = 2'h0;
				end else if (period_tick) begin
					if (clean_cnt == `PSFS_CLEAN_PERIODS - 2'h1) begin
						next_fault_pending = 1'b0; // R3
						next_fault_cnt     = 22'h0;
						next_clean_cnt     = 2'h0;
					end else begin
						next_clean_cnt = clean_cnt + 2'h1; // R3
					end
				end
			end
		end
	end

	// Register the fault state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fault_pending <= 1'b0;
			fault_latched <= 1'b0;
			fault_cnt     <= 22'h0;
			clean_cnt     <= 2'h0;
		end else begin
			fault_pending <= next_fault_pending;
			fault_latched <= next_fault_latched;
			fault_cnt     <= next_fault_cnt;
			clean_cnt     <= next_clean_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Power stage outputs, all registered
	// ----------------------------------------------------------------
	logic next_gate;
	logic next_ss_ground;
	logic next_hyst;
	logic next_drv_reset;
	logic next_min_ton;
	logic active;

	assign active = (state == psfs_pkg::PSFS_ACTIVE);

	// Gate needs every permission at once; any one drops it next cycle
	always_comb begin
		next_gate      = vmin_s & mon_s & ~fault_latched & active & fb_skip_s; // R19 R2 R15
		next_ss_ground = ~active; // R9 R13
		next_hyst      = ~mon_s; // R12
		next_drv_reset = active & ~ss_done_s & cs_ss_s; // R14
		next_min_ton   = fb_skip_s & fb_minton_s; // R15
	end

	// Register the outputs
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gate_enable_out             <= 1'b0;
			ss_ground_out               <= 1'b1;
			hysteresis_current_sink_out <= 1'b1;
			drive_latch_reset_out       <= 1'b0;
			min_ton_out                 <= 1'b0;
			fault_latched_out           <= 1'b0;
		end else begin
			gate_enable_out             <= next_gate;
			ss_ground_out               <= next_ss_ground;
			hysteresis_current_sink_out <= next_hyst;
			drive_latch_reset_out       <= next_drv_reset;
			min_ton_out                 <= next_min_ton;
			fault_latched_out           <= fault_latched;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------------------------------
	logic        wr_pend;
	logic        next_wr_pend;
	logic [7:0]  wr_ofs;
	logic [7:0]  next_wr_ofs;
	logic [31:0] next_hrdata;
	logic        addr_ok;

	assign addr_ok       = hsel_in & hready_in & htrans_in[1];
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// Read data uses the post-write variant so a read right after a write sees it
	always_comb begin
		next_wr_pend = addr_ok & hwrite_in;
		next_wr_ofs  = haddr_in[7:0];
		next_variant = variant;
		next_hrdata  = hrdata_out;
		if (wr_pend && wr_ofs == `PSFS_CTRL_OFS) begin
			next_variant = psfs_pkg::psfs_variant_type'(hwdata_in[`PSFS_VAR_MSB:0]);
		end
		if (addr_ok && !hwrite_in) begin
			case (haddr_in[7:0])
				`PSFS_CTRL_OFS: begin
					next_hrdata = {29'h0, next_variant};
				end
				`PSFS_STATUS_OFS: begin
					next_hrdata = {22'h0, clean_cnt, cs_fault_s, mon_s, vmin_s,
						gate_enable_out, fault_latched, fault_pending, state};
				end
				default: begin
					next_hrdata = 32'h0;
				end
			endcase
		end
	end

	// Register the bus state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_pend    <= 1'b0;
			wr_ofs     <= 8'h00;
			variant    <= psfs_pkg::psfs_variant_type'(`PSFS_CTRL_RESET);
			hrdata_out <= 32'h0;
		end else begin
			wr_pend    <= next_wr_pend;
			wr_ofs     <= next_wr_ofs;
			variant    <= next_variant;
			hrdata_out <= next_hrdata;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_boot_delay;
		state == psfs_pkg::PSFS_OFF && vmin_s && vcc_start_s && has_delay;
	endsequence
	sequence s_boot_direct;
		state == psfs_pkg::PSFS_OFF && vmin_s && vcc_start_s && !has_delay;
	endsequence
	sequence s_delay_end;
		state == psfs_pkg::PSFS_DELAY && vmin_s && delay_cnt == DELAY_LEN - 22'h1;
	endsequence
	sequence s_mon_drop;
		active && !mon_s && vmin_s;
	endsequence

	fault_start_a: assert property ( // R1
		cs_fault_s && !fault_latched && !clear_latch && !expire |=> fault_pending
	) else $error("fault indication did not start the timer");

	latch_gate_a: assert property ( // R2
		fault_latched |=> !gate_enable_out ##1 !gate_enable_out || !fault_latched
	) else $error("gate enabled with latched fault");

	clean_clear_a: assert property ( // R3
		fault_pending && !fault_latched && !clear_latch && !cs_fault_s && !expire
		&& period_tick && clean_cnt == 2'h2 |=> !fault_pending && fault_cnt == 22'h0
	) else $error("timer not cleared after three clean periods");

	early_hold_a: assert property ( // R3
		fault_pending && !clear_latch && cs_fault_s && !expire |=> fault_pending
	) else $error("timer cleared while fault active");

	latch_hold_a: assert property ( // R4
		fault_latched && !clear_latch |=> fault_latched
	) else $error("latched fault cleared without reset event");

	fault_len_a: assert property ( // R5
		$rose(fault_latched) |-> $past(fault_cnt) == fault_limit - 22'h1
	) else $error("fault timer length wrong");

	delay_run_a: assert property ( // R6
		s_boot_delay |=> state == psfs_pkg::PSFS_DELAY && delay_cnt == 22'h0
	) else $error("start-up delay not entered");

	delay_end_a: assert property ( // R8
		s_delay_end ##1 mon_s && vmin_s |=> active
	) else $error("soft-start not permitted after delay");

	no_delay_a: assert property ( // R7
		s_boot_direct |=> state == psfs_pkg::PSFS_WAIT_MON
	) else $error("variant without delay ran the delay");

	ss_hold_a: assert property ( // R9
		!active |=> ss_ground_out
	) else $error("soft-start node released early");

	restart_a: assert property ( // R10
		s_mon_drop ##1 (mon_s && vmin_s) |=> active
	) else $error("restart did not skip the delay");

	hyst_a: assert property ( // R12
		##1 hysteresis_current_sink_out == !$past(mon_s)
	) else $error("hysteresis sink does not follow monitor");

	drive_cut_a: assert property ( // R14
		active && !ss_done_s && cs_ss_s |=> drive_latch_reset_out
	) else $error("drive latch not reset during soft-start");

	skip_a: assert property ( // R15
		!fb_skip_s |=> !gate_enable_out && !min_ton_out
	) else $error("pulses issued below skip level");
endmodule

// *** psfs_stage_model.sv ***
/*
 Model of the power stage, input divider and feedback network.
 Assumes the bench commands levels on clk_in and the sequencer grounds the soft-start node.
*/
`timescale 1ns/1ns

module psfs_stage_model #(
	parameter int OSC_HALF  = 2,
	parameter int SS_CYCLES = 24
) (
	// Clock and bench commands
	input  wire logic       clk_in,
	input  wire logic       supply_on_in,
	input  wire logic       mon_on_in,
	input  wire logic       overload_in,
	input  wire logic       ss_limit_in,
	input  wire logic [1:0] fb_level_in,
	input  wire logic       ss_ground_in,
	// Comparator levels
	output logic            vcc_start_out,
	output logic            vcc_min_out,
	output logic            mon_out,
	output logic            cs_fault_out,
	output logic            cs_ss_out,
	output logic            fb_skip_out,
	output logic            fb_min_ton_out,
	output logic            ss_done_out,
	output logic            osc_out
);
	int osc_cnt = 0;
	int ss_cnt  = 0;
	initial osc_out = 1'b0;

	// Free-running oscillator square wave, the only period source
	always @(posedge clk_in) begin
		osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
		if (osc_cnt == OSC_HALF - 1) begin
			osc_out <= ~osc_out;
		end
	end

	// Capacitor charges only once released; grounding empties it at once
	always @(posedge clk_in) begin
		ss_cnt <= ss_ground_in ? 0 : (ss_cnt < SS_CYCLES ? ss_cnt + 1 : ss_cnt);
	end

	// Comparators; start and minimum move together in this simple supply
	assign ss_done_out    = (ss_cnt >= SS_CYCLES);
	assign vcc_start_out  = supply_on_in;
	assign vcc_min_out    = supply_on_in;
	assign mon_out        = mon_on_in;
	assign cs_fault_out   = overload_in;
	assign cs_ss_out      = ss_limit_in;
	assign fb_skip_out    = (fb_level_in != 2'h0);
	assign fb_min_ton_out = (fb_level_in == 2'h1);
endmodule

// *** tb_pwm_startup_fault_sequencer.sv ***
/*
 Self-checking bench of the start-up and fault sequencer.
 Assumes the stage model supplies every comparator level; small counts shorten the run.
*/
`timescale 1ns/1ns
`include "psfs_cfg.svh"

module tb_pwm_startup_fault_sequencer;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int DLY = 30;
	typedef struct { logic [2:0] vr; logic dly; int flt; } psfs_row_type;
	psfs_row_type rows [5] = '{'{3'h0, 1'b1, 40}, '{3'h1, 1'b1, 40}, '{3'h2, 1'b1, 40},
		'{3'h3, 1'b0, 40}, '{3'h4, 1'b0, 80}};
	logic              clk_in    = 1'b0;
	logic              resetn_in = 1'b0;
	logic              hsel      = 1'b0;
	logic [31:0]       haddr     = 32'h0;
	logic [1:0]        htrans    = 2'h0;
	logic              hwrite    = 1'b0;
	logic [2:0]        hsize     = 3'h2;
	logic [31:0]       hwdata    = 32'h0;
	logic              supply    = 1'b0;
	logic              mon       = 1'b1;
	logic              ovl       = 1'b0;
	logic              ssl       = 1'b0;
	logic [1:0]        fb        = 2'h2;
	logic [31:0]       hrdata, rd;
	logic              hready, hresp, vst, vmin, monl, csf, css, fbs, fbm, ssd, osc;
	logic              gate, ssg, sink, drvr, mton, flat;
	logic signed [3:0] trim, tmin, tmax;
	int                fails       = 0;
	int                check_count = 0;
	int                n;

	// Clock of 40 ns
	initial begin
		forever #20 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	psfs_sequencer #(.FAULT_STD_CYCLES(40), .FAULT_EXT_CYCLES(80), .DELAY_CYCLES(DLY)) dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
		.hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.vcc_start_in(vst), .vcc_min_in(vmin), .input_monitor_pin_in(monl),
		.cs_fault_in(csf), .cs_ss_limit_in(css), .feedback_input_skip_in(fbs),
		.feedback_input_min_ton_in(fbm), .ss_done_in(ssd), .osc_period_in(osc),
		.gate_enable_out(gate), .ss_ground_out(ssg), .hysteresis_current_sink_out(sink),
		.drive_latch_reset_out(drvr), .min_ton_out(mton), .fault_latched_out(flat),
		.dither_trim_out(trim));
	psfs_stage_model model (
		.clk_in(clk_in), .supply_on_in(supply), .mon_on_in(mon), .overload_in(ovl),
		.ss_limit_in(ssl), .fb_level_in(fb), .ss_ground_in(ssg), .vcc_start_out(vst),
		.vcc_min_out(vmin), .mon_out(monl), .cs_fault_out(csf), .cs_ss_out(css),
		.fb_skip_out(fbs), .fb_min_ton_out(fbm), .ss_done_out(ssd), .osc_out(osc));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Single word transfer; the wait ends only on hready, the watchdog bounds it
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge clk_in); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// Counts edges until a level shows, bounded
	task automatic wait_on(ref logic sig, input logic lvl);
		n = 0;
		while (sig !== lvl && n < 400) begin
			@(posedge clk_in);
			n++;
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic edges(input int k);
		repeat (k) @(posedge clk_in);
	endtask

	// Watchdog well beyond the expected run of about a thousand cycles
	initial begin
		edges(20000);
		fails++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		edges(3);
		resetn_in <= 1'b1;
		edges(1);
		check("reset_out", {gate, ssg, sink, flat, trim, hready, hresp}, 10'h182);
		// One row per variant: start-up delay, then overload latch time
		foreach (rows[i]) begin
			ahb(1'b1, {24'h0, `PSFS_CTRL_OFS}, {29'h0, rows[i].vr});
			ahb(1'b0, {24'h0, `PSFS_CTRL_OFS}, 32'h0);
			check("ctrl", rd, {29'h0, rows[i].vr});
			supply <= 1'b0;
			edges(6);
			check("latch_clear", flat, 1'b0);
			supply <= 1'b1;
			wait_on(ssg, 1'b0);
			check("long_delay", n >= DLY, rows[i].dly);
			check("gate_on", gate, 1'b1);
			ovl <= 1'b1;
			wait_on(flat, 1'b1);
			check("fault_time", n >= rows[i].flt && n <= rows[i].flt + 8, 1'b1);
			ovl <= 1'b0;
			edges(30);
			check("gate_off", gate, 1'b0);
		end
		// Brown-out clears the latch; the restart skips the delay of variant A
		ahb(1'b1, {24'h0, `PSFS_CTRL_OFS}, 32'h0);
		mon <= 1'b0;
		edges(6);
		check("brown_out", {flat, gate, ssg, sink}, 4'h3);
		mon <= 1'b1;
		wait_on(ssg, 1'b0);
		check("restart_fast", n < DLY, 1'b1);
		check("sink_off", {sink, gate}, 2'h1);
		// Soft-start current limit only while the node is still charging
		ssl <= 1'b1;
		edges(5);
		check("ss_limit", drvr, 1'b1);
		edges(40);
		check("ss_over", drvr, 1'b0);
		ssl <= 1'b0;
		fb  <= 2'h1;
		edges(5);
		check("min_ton", {mton, gate}, 2'h3);
		fb <= 2'h0;
		edges(5);
		check("skip", gate, 1'b0);
		fb <= 2'h2;
		edges(5);
		ahb(1'b0, {24'h0, `PSFS_STATUS_OFS}, 32'h0);
		check("status", {rd[4], rd[1:0]}, 3'h7);
		ahb(1'b0, 32'h8, 32'h0);
		check("unmapped", rd, 32'h0);
		// Dither must sweep the full band
		tmin = 4'sh0;
		tmax = 4'sh0;
		repeat (120) begin
			@(posedge clk_in);
			if (trim < tmin) tmin = trim;
			if (trim > tmax) tmax = trim;
		end
		check("trim_band", {tmin, tmax}, 8'hb5);
		// Bursts split by long clean gaps never add up
		repeat (2) begin
			ovl <= 1'b1;
			edges(12);
			ovl <= 1'b0;
			edges(40);
		end
		check("clean_reset", flat, 1'b0);
		// Gaps shorter than three periods keep the timer running
		repeat (3) begin
			ovl <= 1'b1;
			edges(12);
			ovl <= 1'b0;
			edges(4);
		end
		edges(10);
		check("short_gaps", {flat, gate}, 2'h2);
		// Reset in mid-run returns the outputs and the variant to their reset values
		resetn_in <= 1'b0;
		edges(3);
		check("reset_mid", {gate, ssg, flat}, 3'h2);
		resetn_in <= 1'b1;
		edges(1);
		ahb(1'b0, {24'h0, `PSFS_CTRL_OFS}, 32'h0);
		check("ctrl_reset", rd, 32'h0);
		complete_run();
	end
endmodule
